// ===== design/rpc_calib.sv
// Purpose: crystal divider chain with periodic calibration and control byte
// Assumes: crystal level and SRAM bus pins are asynchronous to clk_sys_in
// Notes:   one clock; every crystal and bus pin passes the two-stage synchroniser first
`timescale 1ns/100ps
`default_nettype none
module rpc_calib
  import rpc_pkg::*;
(
  input  wire logic              clk_sys_in,
  input  wire logic              reset_in,
  input  wire logic              xtal_in,        // crystal square wave
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic              chip_en_n_in,
  input  wire logic              write_en_n_in,
  input  wire logic              out_en_n_in,
  input  wire logic [7:0]        data_in,
  output logic      [7:0]        data_out,
  output logic                   data_oe_out,
  output logic                   sec_tick_out,   // one pulse per corrected second
  output logic                   time_load_out,  // transfer loaded time into counters
  output logic                   regs_hold_out,  // time registers frozen
  output logic      [7:0]        ctrl_out
);
  localparam int SW = 3 + 1 + ADDR_W + 8;

  typedef struct packed {
    rpc_mode_t        mode;
    logic [7:0]       ctrl;
    logic [PRE_W-1:0] pre;
    logic [STG_W-1:0] stg;
    logic [5:0]       sec;
    logic [5:0]       min;
    logic             corr;     // current second is being altered
    logic             sign;     // direction latched for that second
    logic             sec_tick;
    logic             load;
    logic             osc_d;
    logic             wr_act_d;
    logic             oe;
    logic [7:0]       dout;
    logic [1:0]       settle;   // synchroniser output trusted once bit 1 is set
  } rpc_state_t;

  rpc_state_t s_q;
  rpc_state_t s_d;

  logic [SW-1:0]     sync_w;
  logic              xtal_s;
  logic              ce_n_s;
  logic              we_n_s;
  logic              oe_n_s;
  logic [ADDR_W-1:0] addr_s;
  logic [7:0]        data_s;
  logic              osc_tick;
  logic              wr_act;
  logic              commit;
  logic              sel;

  // all pins share one delay so address and data stay aligned with strobes
  rpc_sync #(.W(SW)) u_sync (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .async_in   ({xtal_in, chip_en_n_in, write_en_n_in, out_en_n_in, addr_in, data_in}),
    .sync_out   (sync_w)
  );
  assign {xtal_s, ce_n_s, we_n_s, oe_n_s, addr_s, data_s} = sync_w;

  // decide whether a second starting at (sec, min) gets altered
  function automatic logic cal_hits(input logic [5:0] sec, input logic [5:0] min,
                                    input logic [7:0] ctrl);
    logic [4:0] mag;
    mag = ctrl[MAG_MSB:0];
    cal_hits = (mag != 5'h00) && (sec == CAL_SEC)
               && (min < {mag, 1'b0});
  endfunction

  // bus decode: a write ends at the earlier rise of either strobe
  assign sel      = (addr_s == CTRL_ADDR);
  assign osc_tick = xtal_s & ~s_q.osc_d;
  // the synchroniser shows its reset zeros, which look like active strobes,
  // for two edges after reset; a write decoded from them would be false
  assign wr_act   = ~ce_n_s & ~we_n_s & s_q.settle[1];
  assign commit   = s_q.wr_act_d & ~wr_act & sel;

  // next state of the whole block
  always_comb begin
    logic [PRE_W-1:0] pre_end;
    logic [STG_W-1:0] stg_end;
    logic [5:0]       nsec;
    logic [5:0]       nmin;
    pre_end    = PRE_LAST;
    stg_end    = STG_LAST;
    nsec       = s_q.sec;
    nmin       = s_q.min;
    s_d          = s_q;
    s_d.sec_tick = 1'b0;
    s_d.load     = 1'b0;
    s_d.osc_d    = xtal_s;
    s_d.wr_act_d = wr_act;
    s_d.settle   = {s_q.settle[0], 1'b1};

    // control byte write; sign and magnitude take effect at the next second boundary, read and write bits at once
    if (commit) begin
      s_d.ctrl = data_s;
    end

    // write bit handshake with the time counters outside
    case (s_q.mode)
      RPC_RUN: begin
        if (s_q.ctrl[BIT_WRITE]) begin
          s_d.mode = RPC_WRHOLD;
        end
      end
      RPC_WRHOLD: begin
        if (!s_q.ctrl[BIT_WRITE]) begin
          s_d.mode = RPC_LOAD;
        end
      end
      RPC_LOAD: begin
        s_d.load = 1'b1;
        s_d.pre  = '0;
        s_d.stg  = '0;
        s_d.mode = RPC_RUN;
      end
      default: begin
        s_d.mode = RPC_RUN;
      end
    endcase

    // divider chain; a slowed second stretches its first 256-stage period,
    // a sped second drops one 256-stage step
    if (osc_tick && s_q.mode != RPC_LOAD) begin
      if (s_q.corr && !s_q.sign && s_q.stg == '0) begin
        pre_end = PRE_LAST_NEG;
      end
      if (s_q.corr && s_q.sign) begin
        stg_end = STG_LAST_POS;
      end
      if (s_q.pre == pre_end) begin
        s_d.pre = '0;
        if (s_q.stg == stg_end) begin
          s_d.stg      = '0;
          s_d.sec_tick = 1'b1;
          if (s_q.sec == SEC_LAST) begin
            nsec = '0;
            nmin = (s_q.min == MIN_LAST) ? 6'h00 : s_q.min + 6'h01;
          end else begin
            nsec = s_q.sec + 6'h01;
          end
          s_d.sec  = nsec;
          s_d.min  = nmin;
          s_d.corr = cal_hits(nsec, nmin, s_q.ctrl);
          s_d.sign = s_q.ctrl[BIT_SIGN];
        end else begin
          s_d.stg = s_q.stg + {{(STG_W-1){1'b0}}, 1'b1};
        end
      end else begin
        s_d.pre = s_q.pre + {{(PRE_W-1){1'b0}}, 1'b1};
      end
    end

    // read path: drive while selected for reading
    s_d.oe   = ~ce_n_s & ~oe_n_s & we_n_s & sel;
    s_d.dout = s_q.ctrl;
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      s_q      <= '0;
      s_q.mode <= RPC_RUN;
      s_q.ctrl <= CTRL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign data_out      = s_q.dout;
  assign data_oe_out   = s_q.oe;
  assign sec_tick_out  = s_q.sec_tick;
  assign time_load_out = s_q.load;
  assign regs_hold_out = s_q.ctrl[BIT_READ] | s_q.ctrl[BIT_WRITE];
  assign ctrl_out      = s_q.ctrl;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);

  AST_LOAD_AFTER_CLEAR: assert property (
    (s_q.mode == RPC_WRHOLD && !s_q.ctrl[BIT_WRITE]) |=> ##1 (time_load_out && s_q.pre == '0 && s_q.stg == '0))
    else $error("time load did not follow write bit clear");
  AST_HOLD_ON_READ: assert property (
    $rose(s_q.ctrl[BIT_READ]) |-> regs_hold_out [*3])
    else $error("read bit did not freeze time registers");
  AST_ZERO_MAG: assert property (
    (sec_tick_out && $past(s_q.ctrl[MAG_MSB:0]) == 5'h00) |-> !s_q.corr)
    else $error("second altered with zero magnitude");
  AST_MIN_WINDOW: assert property (
    (sec_tick_out && s_q.min >= {$past(s_q.ctrl[MAG_MSB:0]), 1'b0}) |-> !s_q.corr)
    else $error("altered minute outside first 2N");
  AST_MAX_62: assert property (
    s_q.corr |-> (s_q.min < 6'h3e && s_q.sec == CAL_SEC))
    else $error("altered second outside allowed place");
  AST_PRE_BOUND: assert property (
    (!s_q.corr || s_q.sign || s_q.stg != '0) |-> s_q.pre <= PRE_LAST)
    else $error("prescaler overran outside stretched period");
  AST_POS_SHORT: assert property (
    (s_q.corr && s_q.sign) |-> s_q.stg <= STG_LAST_POS)
    else $error("sped second not shortened");
  AST_WR_STORE: assert property (
    commit |=> s_q.ctrl == $past(data_s))
    else $error("control byte write not stored");
  AST_WR_NO_DISTURB: assert property (
    (commit && s_q.mode == RPC_RUN && !osc_tick) |=> (s_q.pre == $past(s_q.pre) && s_q.sec == $past(s_q.sec)))
    else $error("calibration write disturbed the divider");
endmodule // rpc_calib
`default_nettype wire

// ===== design/rpc_pkg.sv
// Purpose: shared constants and types for the periodic calibration block
// Assumes: 32768 Hz crystal, byte-wide asynchronous SRAM-style bus
// Notes:   the divider counter limits derive from the crystal and stage divisors
package rpc_pkg;

  // crystal and divider chain
  localparam int XTAL_HZ      = 32768;
  localparam int PRE_DIV      = 256;                  // correction stage
  localparam int STG_DIV      = XTAL_HZ / PRE_DIV;    // 128 steps per second
  localparam int NEG_ADD_CYC  = 128;                  // cycles added on a slowed second
  localparam int POS_CUT_CYC  = 256;                  // cycles removed on a sped second
  localparam int PRE_W        = 9;
  localparam int STG_W        = 7;

  localparam logic [PRE_W-1:0] PRE_LAST     = PRE_W'(PRE_DIV - 1);
  localparam logic [PRE_W-1:0] PRE_LAST_NEG = PRE_W'(PRE_DIV + NEG_ADD_CYC - 1);
  localparam logic [STG_W-1:0] STG_LAST     = STG_W'(STG_DIV - 1);
  localparam logic [STG_W-1:0] STG_LAST_POS = STG_W'(STG_DIV - 1 - POS_CUT_CYC / PRE_DIV);

  // second and minute tracking inside the correction cycle
  localparam logic [5:0] SEC_LAST     = 6'h3b;        // 60 seconds per minute
  localparam logic [5:0] MIN_LAST     = 6'h3f;        // 64 minute cycle
  localparam logic [5:0] CAL_SEC      = 6'h00;        // second that gets altered

  // control byte
  localparam int         ADDR_W       = 19;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 19'h07ff8;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam int         BIT_WRITE    = 7;
  localparam int         BIT_READ     = 6;
  localparam int         BIT_SIGN     = 5;
  localparam int         MAG_MSB      = 4;

  typedef enum logic [2:0] {
    RPC_RUN    = 3'b001,
    RPC_WRHOLD = 3'b010,
    RPC_LOAD   = 3'b100
  } rpc_mode_t;

endpackage

// ===== design/rpc_sync.sv
// Purpose: two-stage synchroniser for asynchronous pins
// Assumes: inputs are quasi-static relative to the system clock
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module rpc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_in,
  input  wire logic         reset_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } rpc_sync_t;

  rpc_sync_t s_q;
  rpc_sync_t s_d;

  // elaboration-time refusal of an empty bus
  if (W < 1) begin : g_width_check
    $error("rpc_sync: width must be positive");
  end

  // shift one stage per clock
  always_comb begin
    s_d.meta = async_in;
    s_d.stab = s_q.meta;
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stab;
endmodule // rpc_sync
`default_nettype wire

// ===== verif/rpc_host.sv
// Purpose: host model that reaches the control byte over the byte-wide bus
// Assumes: reads have a fixed latency, the bus carries no ready signal
// Notes:   released data lines show the inverse of the last byte
`timescale 1ns/100ps
`default_nettype none
module rpc_host
  import rpc_pkg::*;
(
  input  wire logic              clk_sys_in,
  input  wire logic [7:0]        rd_data_in,
  input  wire logic              rd_oe_in,
  output logic      [ADDR_W-1:0] addr_out,
  output logic                   chip_en_n_out,
  output logic                   write_en_n_out,
  output logic                   out_en_n_out,
  output logic      [7:0]        wr_data_out
);
  // idle bus: all strobes high
  initial begin
    addr_out       = '0;
    chip_en_n_out  = 1'b1;
    write_en_n_out = 1'b1;
    out_en_n_out   = 1'b1;
    wr_data_out    = 8'h00;
  end

  // strobes held 6 cycles so the two-stage sync cannot miss them
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    addr_out       = a;
    wr_data_out    = d;
    chip_en_n_out  = 1'b0;
    write_en_n_out = 1'b0;
    repeat (6) @(negedge clk_sys_in);
    write_en_n_out = 1'b1;
    chip_en_n_out  = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    wr_data_out    = ~d;   // hold time over, stale byte must not linger
    repeat (2) @(negedge clk_sys_in);
  endtask

  // sampled on a falling edge, well past the 3 cycle answer
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d, output logic oe);
    @(negedge clk_sys_in);
    addr_out      = a;
    chip_en_n_out = 1'b0;
    out_en_n_out  = 1'b0;
    repeat (5) @(negedge clk_sys_in);
    d             = rd_data_in;
    oe            = rd_oe_in;
    chip_en_n_out = 1'b1;
    out_en_n_out  = 1'b1;
    repeat (5) @(negedge clk_sys_in);
  endtask
endmodule // rpc_host
`default_nettype wire

// ===== verif/tb_rtc_periodic_calibration.sv
// Purpose: self-checking bench for the calibration control byte and divider
// Assumes: crystal toggles every system cycle, one second is 65536 cycles
// Notes:   only one second is timed to keep the run short
`timescale 1ns/100ps
`default_nettype none
module tb_rtc_periodic_calibration;
  import rpc_pkg::*;
  logic              clk_sys_in, reset_in, xtal_in;
  logic [ADDR_W-1:0] addr;
  logic              ce_n, we_n, oe_n, oe, hold, tick, load, drv;
  logic [7:0]        wdat, rdat, ctrl, d;
  logic [7:0]        vals [4] = '{8'h1f, 8'h20, 8'h3f, 8'h00};
  int                error_cnt, cmp_count, load_cnt, tick_cnt, edges, load_e, tick_e;

  rpc_calib u_rpc_calib (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .xtal_in(xtal_in),
    .addr_in(addr), .chip_en_n_in(ce_n), .write_en_n_in(we_n), .out_en_n_in(oe_n),
    .data_in(wdat), .data_out(rdat), .data_oe_out(oe), .sec_tick_out(tick),
    .time_load_out(load), .regs_hold_out(hold), .ctrl_out(ctrl));
  rpc_host u_rpc_host (.clk_sys_in(clk_sys_in), .rd_data_in(rdat), .rd_oe_in(oe),
    .addr_out(addr), .chip_en_n_out(ce_n), .write_en_n_out(we_n),
    .out_en_n_out(oe_n), .wr_data_out(wdat));

  // clocks: crystal changes on the falling edge, well clear of sampling
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    xtal_in = 1'b0;
    forever @(negedge clk_sys_in) xtal_in = ~xtal_in;
  end

  // pulse monitors, crystal edge positions of load and tick
  always @(posedge xtal_in) edges++;
  always @(negedge clk_sys_in) begin
    if (load === 1'b1) begin
      load_cnt++;
      load_e = edges;
    end
    if (tick === 1'b1 && load_cnt > 0) begin
      tick_cnt++;
      tick_e = edges;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // watchdog sized for one timed second plus the register tests
  initial begin
    #(90000 * 5);
    error_cnt++;
    give_verdict();
  end

  initial begin
    reset_in = 1'b1;
    repeat (16) @(negedge clk_sys_in);
    reset_in = 1'b0;
    u_rpc_host.rd(CTRL_ADDR, d, drv);
    chk({d, drv}, {CTRL_RESET, 1'b1});
    // magnitude and sign fields of the byte written and read back
    foreach (vals[i]) begin
      u_rpc_host.wr(CTRL_ADDR, vals[i]);
      u_rpc_host.rd(CTRL_ADDR, d, drv);
      chk({d, ctrl}, {vals[i], vals[i]});
    end
    // unmapped address neither writes nor answers
    u_rpc_host.wr(CTRL_ADDR - 19'h1, 8'h15);
    u_rpc_host.rd(CTRL_ADDR - 19'h1, d, drv);
    chk({ctrl, drv}, {8'h00, 1'b0});
    u_rpc_host.wr(CTRL_ADDR, 8'h40);
    chk(hold, 1'b1);
    u_rpc_host.wr(CTRL_ADDR, 8'h00);
    chk({hold, load_cnt[3:0]}, {1'b0, 4'h0});
    u_rpc_host.wr(CTRL_ADDR, 8'ha0);
    chk({hold, load_cnt[3:0]}, {1'b1, 4'h0});
    u_rpc_host.wr(CTRL_ADDR, 8'h20);
    chk({hold, load_cnt[3:0]}, {1'b0, 4'h1});
    // calibration changed in mid-second must not disturb the running divider
    repeat (30000) @(negedge clk_sys_in);
    u_rpc_host.wr(CTRL_ADDR, 8'h3f);
    for (int n = 0; n < 40000 && tick_cnt == 0; n++) @(negedge clk_sys_in);
    chk(tick_cnt, 1);
    chk(tick_e - load_e >= XTAL_HZ - 1 && tick_e - load_e <= XTAL_HZ + 1, 1'b1);
    give_verdict();
  end
endmodule // tb_rtc_periodic_calibration
`default_nettype wire
